// >>> src/pcm_pkg.sv
// Constants for the configuration mirror block: offsets, field positions, reset values.
// Assumes a 32-bit APB register bus and a sampled link clock.
package pcm_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] IDENT_OFFSET   = 12'h000;
    localparam logic [ADDR_W-1:0] CMDSTAT_OFFSET = 12'h004;

    // Identity fields
    localparam int PART_ID_LSB  = 16;
    localparam int MAKER_ID_LSB = 0;
    localparam int ID_W         = 16;
    // Arbitrary neutral reset values
    localparam logic [15:0] PART_ID_RESET  = 16'h0a5a;
    localparam logic [15:0] MAKER_ID_RESET = 16'h0c3c;

    // Status half
    localparam int PAR_FAULT_BIT      = 31;
    localparam int SYS_FAULT_BIT      = 30;
    localparam int INIT_ABORT_BIT     = 29;
    localparam int RESP_ABORT_RCV_BIT = 28;
    localparam int RESP_ABORT_SIG_BIT = 27;
    localparam int SEL_SPEED_LSB      = 25;
    localparam int SEL_SPEED_W        = 2;
    localparam logic [1:0] SEL_SPEED_VAL = 2'h1;
    localparam int INIT_DPAR_BIT      = 24;
    localparam int B2B_CAP_BIT        = 23;
    localparam int HS_CAP_BIT         = 21;
    localparam int CAP_CHAIN_BIT      = 20;
    localparam int IRQ_STAT_BIT       = 19;
    localparam logic CAP_CHAIN_DEFAULT = 1'h1;

    // Command half
    localparam int IRQ_DIS_BIT    = 10;
    localparam int SYSPIN_EN_BIT  = 8;
    localparam int PAR_RESP_BIT   = 6;
    localparam logic CMD_BIT_RESET = 1'h0;

    // Sticky error flags, index to bit position
    localparam int FLAG_N = 5;
    localparam int FLAG_PAR   = 0;
    localparam int FLAG_SYS   = 1;
    localparam int FLAG_INIT  = 2;
    localparam int FLAG_RESP  = 3;
    localparam int FLAG_DPAR  = 4;
    localparam int FLAG_POS [FLAG_N] = '{31, 30, 29, 28, 24};
    localparam logic [FLAG_N-1:0] FLAG_RESET = 5'h00;

    // Pin sampler lanes
    localparam int LANE_N        = 6;
    localparam int LANE_PERR_IN  = 0;
    localparam int LANE_PAR_EVT  = 1;
    localparam int LANE_SYS_REQ  = 2;
    localparam int LANE_INIT_AB  = 3;
    localparam int LANE_RESP_AB  = 4;
    localparam int LANE_OWNER    = 5;

    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic {
        PCM_IDLE  = 1'b0,
        PCM_REPLY = 1'b1
    } pcm_apb_state_t;

endpackage

// >>> src/pcm_pin_sync.sv
// Two-flop synchroniser for link-side pins plus rising-edge finder for the link clock.
// Assumes the link clock is much slower than the local clock.
module pcm_pin_sync #(
    parameter int W = 6
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pins_in,
    input  wire logic         link_clk_in,
    output logic      [W-1:0] pins_sync,
    output logic              link_rise
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic         clk_meta_reg;
    logic         clk_sync_reg;
    logic         clk_last_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= pins_in;
            sync_reg <= meta_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clk_meta_reg <= 1'b0;
            clk_sync_reg <= 1'b0;
            clk_last_reg <= 1'b0;
        end else begin
            clk_meta_reg <= link_clk_in;
            clk_sync_reg <= clk_meta_reg;
            clk_last_reg <= clk_sync_reg;
        end
    end

    assign pins_sync = sync_reg;
    assign link_rise = clk_sync_reg & ~clk_last_reg;

endmodule

// >>> src/pcm_cfg_mirror.sv
// Configuration identity and command/status mirror with APB register access.
// Assumes PCI-side event pins are held over at least one link clock period.
//
// Summary of operation
// - Identity word: part identifier high half, maker identifier low half, both writable.
// - Bit 31 sets on any parity error, even with parity reporting off.
// - Bit 30 sets whenever the system fault pin is driven.
// - Bit 29 sets when an own transaction ends in initiator abort.
// - Bit 28 records responder abort received as bus master, set only by master.
// - Bit 27 always reads 0; no responder abort is ever issued.
// - Bits 26-25 are hardwired 01, medium select decode speed.
// - Bit 24 sets on parity pin driven or seen, while master, response enabled.
// - Bit 23 back-to-back capability is hardwired 0.
// - Bit 21 high speed capability is read-only 0.
// - Bit 20 is a read-only capability chain present indicator.
// - Bit 19 shows current function interrupt state, unaffected by pin disable.
// - Interrupt pin driven low when bit 19 set and bit 10 clear.
// - Bit 10 set turns off the interrupt pin driver.
// - Reserved status bits 18-11 read 0.
// - With bit 6 clear, parity flag still sets but parity pin stays undriven.
// - Bit 8 enables the system fault pin driver; clear keeps faults off the pin.
//
// Added by the designer: the APB interface to the registers and the address map.
module pcm_cfg_mirror #(
    parameter logic [15:0] PART_ID_DEFAULT  = pcm_pkg::PART_ID_RESET,
    parameter logic [15:0] MAKER_ID_DEFAULT = pcm_pkg::MAKER_ID_RESET,
    parameter logic        CAP_CHAIN        = pcm_pkg::CAP_CHAIN_DEFAULT
) (
    input  wire logic                        CLOCK,
    input  wire logic                        RSTN,
    // APB slave
    input  wire logic                        PSEL,
    input  wire logic                        PENABLE,
    input  wire logic                        PWRITE,
    input  wire logic [pcm_pkg::ADDR_W-1:0]  PADDR,
    input  wire logic [pcm_pkg::DATA_W-1:0]  PWDATA,
    output logic      [pcm_pkg::DATA_W-1:0]  PRDATA,
    output logic                             PREADY,
    output logic                             PSLVERR,
    // Link side
    input  wire logic                        LINK_CLK,
    input  wire logic                        PAR_FAULT_EVT,
    input  wire logic                        SYS_FAULT_REQ,
    input  wire logic                        INIT_ABORT_EVT,
    input  wire logic                        RESP_ABORT_EVT,
    input  wire logic                        BUS_OWNER,
    input  wire logic                        FUNC_IRQ_STATE,
    input  wire logic                        PARITY_FAULT_PIN_N_I,
    output logic                             PARITY_FAULT_PIN_N_O,
    output logic                             PARITY_FAULT_PIN_OE,
    output logic                             SYSTEM_FAULT_PIN_N_O,
    output logic                             SYSTEM_FAULT_PIN_OE,
    output logic                             IRQ_PIN_N_O,
    output logic                             IRQ_PIN_OE
);

    // Pin sampling
    logic [pcm_pkg::LANE_N-1:0] lane_raw;
    logic [pcm_pkg::LANE_N-1:0] lane_sync;
    logic                       link_rise;

    always_comb begin
        lane_raw                        = '0;
        lane_raw[pcm_pkg::LANE_PERR_IN] = ~PARITY_FAULT_PIN_N_I;
        lane_raw[pcm_pkg::LANE_PAR_EVT] = PAR_FAULT_EVT;
        lane_raw[pcm_pkg::LANE_SYS_REQ] = SYS_FAULT_REQ;
        lane_raw[pcm_pkg::LANE_INIT_AB] = INIT_ABORT_EVT;
        lane_raw[pcm_pkg::LANE_RESP_AB] = RESP_ABORT_EVT;
        lane_raw[pcm_pkg::LANE_OWNER]   = BUS_OWNER;
    end

    pcm_pin_sync #(
        .W           (pcm_pkg::LANE_N)
    ) u_pin_sync (
        .clk         (CLOCK),
        .rst_n       (RSTN),
        .pins_in     (lane_raw),
        .link_clk_in (LINK_CLK),
        .pins_sync   (lane_sync),
        .link_rise   (link_rise)
    );

    // Register state
    logic [15:0]                  part_identifier_reg;
    logic [15:0]                  maker_identifier_reg;
    logic                         irq_pin_disable_reg;
    logic                         system_fault_pin_enable_reg;
    logic                         parity_response_enable_reg;
    logic                         irq_status_reg;
    logic [pcm_pkg::FLAG_N-1:0]   flag_reg;
    logic [pcm_pkg::FLAG_N-1:0]   flag_set;
    logic [pcm_pkg::FLAG_N-1:0]   flag_clr;

    // APB handshake
    pcm_pkg::pcm_apb_state_t      state_reg;
    logic [pcm_pkg::DATA_W-1:0]   prdata_reg;
    logic                         pready_reg;
    logic                         pslverr_reg;
    logic [pcm_pkg::DATA_W-1:0]   read_word;
    logic                         hit_ident;
    logic                         hit_cmdstat;
    logic                         access;
    logic                         commit_wr;

    // Link-side drive decisions
    logic                         perr_drive_now;
    logic                         serr_drive_now;
    logic                         perr_seen_now;
    logic                         perr_oe_reg;
    logic                         serr_oe_reg;
    logic                         irq_oe_reg;

    assign hit_ident   = (PADDR == pcm_pkg::IDENT_OFFSET);
    assign hit_cmdstat = (PADDR == pcm_pkg::CMDSTAT_OFFSET);
    assign access      = PSEL & PENABLE;
    assign commit_wr   = access & PWRITE & (state_reg == pcm_pkg::PCM_REPLY) & pready_reg;

    // Readback of the two mirror words
    always_comb begin
        read_word = pcm_pkg::WORD_ZERO;
        if (hit_ident) begin
            read_word[pcm_pkg::PART_ID_LSB +: pcm_pkg::ID_W]  = part_identifier_reg;
            read_word[pcm_pkg::MAKER_ID_LSB +: pcm_pkg::ID_W] = maker_identifier_reg;
        end else if (hit_cmdstat) begin
            for (int i = 0; i < pcm_pkg::FLAG_N; i++) begin
                read_word[pcm_pkg::FLAG_POS[i]] = flag_reg[i];
            end
            read_word[pcm_pkg::RESP_ABORT_SIG_BIT] = 1'b0;
            read_word[pcm_pkg::SEL_SPEED_LSB +: pcm_pkg::SEL_SPEED_W] = pcm_pkg::SEL_SPEED_VAL;
            read_word[pcm_pkg::B2B_CAP_BIT]   = 1'b0;
            read_word[pcm_pkg::HS_CAP_BIT]    = 1'b0;
            read_word[pcm_pkg::CAP_CHAIN_BIT] = CAP_CHAIN;
            read_word[pcm_pkg::IRQ_STAT_BIT]  = irq_status_reg;
            // Bits 18-11 and other unlisted bits stay 0
            read_word[pcm_pkg::IRQ_DIS_BIT]   = irq_pin_disable_reg;
            read_word[pcm_pkg::SYSPIN_EN_BIT] = system_fault_pin_enable_reg;
            read_word[pcm_pkg::PAR_RESP_BIT]  = parity_response_enable_reg;
        end
    end

    // Two-state slave: one wait cycle, then ready
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            state_reg   <= pcm_pkg::PCM_IDLE;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= pcm_pkg::WORD_ZERO;
        end else begin
            unique case (state_reg)
                pcm_pkg::PCM_IDLE: begin
                    if (access) begin
                        state_reg   <= pcm_pkg::PCM_REPLY;
                        pready_reg  <= 1'b1;
                        pslverr_reg <= ~(hit_ident | hit_cmdstat);
                        prdata_reg  <= PWRITE ? pcm_pkg::WORD_ZERO : read_word;
                    end
                end
                pcm_pkg::PCM_REPLY: begin
                    state_reg   <= pcm_pkg::PCM_IDLE;
                    pready_reg  <= 1'b0;
                    pslverr_reg <= 1'b0;
                    prdata_reg  <= pcm_pkg::WORD_ZERO;
                end
            endcase
        end
    end

    // Identity word
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            part_identifier_reg  <= PART_ID_DEFAULT;
            maker_identifier_reg <= MAKER_ID_DEFAULT;
        end else if (commit_wr && hit_ident) begin
            part_identifier_reg  <= PWDATA[pcm_pkg::PART_ID_LSB +: pcm_pkg::ID_W];
            maker_identifier_reg <= PWDATA[pcm_pkg::MAKER_ID_LSB +: pcm_pkg::ID_W];
        end
    end

    // Writable command bits
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            irq_pin_disable_reg         <= pcm_pkg::CMD_BIT_RESET;
            system_fault_pin_enable_reg <= pcm_pkg::CMD_BIT_RESET;
            parity_response_enable_reg  <= pcm_pkg::CMD_BIT_RESET;
        end else if (commit_wr && hit_cmdstat) begin
            irq_pin_disable_reg         <= PWDATA[pcm_pkg::IRQ_DIS_BIT];
            system_fault_pin_enable_reg <= PWDATA[pcm_pkg::SYSPIN_EN_BIT];
            parity_response_enable_reg  <= PWDATA[pcm_pkg::PAR_RESP_BIT];
        end
    end

    // Back-end interrupt state, same clock domain
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            irq_status_reg <= 1'b0;
        end else begin
            irq_status_reg <= FUNC_IRQ_STATE;
        end
    end

    // Link-side conditions, valid at a link clock rise
    assign perr_drive_now = lane_sync[pcm_pkg::LANE_PAR_EVT] & parity_response_enable_reg;
    assign serr_drive_now = lane_sync[pcm_pkg::LANE_SYS_REQ] & system_fault_pin_enable_reg;
    assign perr_seen_now  = perr_drive_now | lane_sync[pcm_pkg::LANE_PERR_IN];

    // Event sets, one per link clock rise
    always_comb begin
        flag_set = '0;
        if (link_rise) begin
            flag_set[pcm_pkg::FLAG_PAR]  = lane_sync[pcm_pkg::LANE_PAR_EVT];
            flag_set[pcm_pkg::FLAG_SYS]  = serr_drive_now;
            flag_set[pcm_pkg::FLAG_INIT] = lane_sync[pcm_pkg::LANE_INIT_AB]
                                         & lane_sync[pcm_pkg::LANE_OWNER];
            flag_set[pcm_pkg::FLAG_RESP] = lane_sync[pcm_pkg::LANE_RESP_AB]
                                         & lane_sync[pcm_pkg::LANE_OWNER];
            flag_set[pcm_pkg::FLAG_DPAR] = perr_seen_now & lane_sync[pcm_pkg::LANE_OWNER]
                                         & parity_response_enable_reg;
        end
    end

    // Write-one-to-clear strobes
    always_comb begin
        flag_clr = '0;
        if (commit_wr && hit_cmdstat) begin
            for (int i = 0; i < pcm_pkg::FLAG_N; i++) begin
                flag_clr[i] = PWDATA[pcm_pkg::FLAG_POS[i]];
            end
        end
    end

    // Sticky flags, set beats clear
    generate
        for (genvar g = 0; g < pcm_pkg::FLAG_N; g++) begin : g_flag
            always_ff @(posedge CLOCK) begin
                if (!RSTN) begin
                    flag_reg[g] <= pcm_pkg::FLAG_RESET[g];
                end else if (flag_set[g]) begin
                    flag_reg[g] <= 1'b1;
                end else if (flag_clr[g]) begin
                    flag_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Fault pin drivers, updated on each link clock rise
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            perr_oe_reg <= 1'b0;
            serr_oe_reg <= 1'b0;
        end else if (link_rise) begin
            perr_oe_reg <= perr_drive_now;
            serr_oe_reg <= serr_drive_now;
        end
    end

    // Interrupt pin driver
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            irq_oe_reg <= 1'b0;
        end else begin
            irq_oe_reg <= irq_status_reg & ~irq_pin_disable_reg;
        end
    end

    // Pins pull low only when enabled
    logic pin_low_reg;
    always_ff @(posedge CLOCK) begin
        pin_low_reg <= 1'b0;
    end

    assign PRDATA               = prdata_reg;
    assign PREADY               = pready_reg;
    assign PSLVERR              = pslverr_reg;
    assign PARITY_FAULT_PIN_N_O = pin_low_reg;
    assign PARITY_FAULT_PIN_OE  = perr_oe_reg;
    assign SYSTEM_FAULT_PIN_N_O = pin_low_reg;
    assign SYSTEM_FAULT_PIN_OE  = serr_oe_reg;
    assign IRQ_PIN_N_O          = pin_low_reg;
    assign IRQ_PIN_OE           = irq_oe_reg;

endmodule

// >>> verification/pcm_cfg_mirror_properties.sv
// Port-level assertions for the configuration mirror.
// Assumes binding to pcm_cfg_mirror; sees only its ports.
module pcm_cfg_mirror_properties #(
    parameter logic CAP_CHAIN = 1'h1
) (
    input wire logic        CLOCK,
    input wire logic        RSTN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        FUNC_IRQ_STATE,
    input wire logic        PARITY_FAULT_PIN_N_O,
    input wire logic        PARITY_FAULT_PIN_OE,
    input wire logic        SYSTEM_FAULT_PIN_N_O,
    input wire logic        SYSTEM_FAULT_PIN_OE,
    input wire logic        IRQ_PIN_N_O,
    input wire logic        IRQ_PIN_OE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    logic       rd_cs;
    logic [2:0] irq_h;
    assign rd_cs = PREADY && !PWRITE && PADDR == pcm_pkg::CMDSTAT_OFFSET;
    // Interrupt input history, newest in bit 0
    always_ff @(posedge CLOCK) irq_h <= {irq_h[1:0], FUNC_IRQ_STATE};

    ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
    ready_wait_a: assert property (PSEL && PENABLE && !$past(PENABLE) |=> PREADY) else $error("ready late");
    idle_data_a: assert property (!PREADY |-> PRDATA == 32'h0 && !PSLVERR) else $error("data outside reply");
    unmapped_err_a: assert property (PREADY |-> PSLVERR == (PADDR != pcm_pkg::IDENT_OFFSET
        && PADDR != pcm_pkg::CMDSTAT_OFFSET)) else $error("error response wrong");
    fixed_bits_a: assert property (
        rd_cs |-> PRDATA[27:25] == 3'h1 && PRDATA[23:20] == {3'h0, CAP_CHAIN} && PRDATA[18:11] == 8'h00)
        else $error("fixed status bits wrong");
    irq_status_a: assert property (
        rd_cs && (irq_h == 3'h7 || irq_h == 3'h0) |-> PRDATA[19] == irq_h[1])
        else $error("interrupt status wrong");
    irq_pin_a: assert property (IRQ_PIN_OE |-> irq_h[1]) else $error("interrupt pin without cause");
    pin_level_a: assert property (!PARITY_FAULT_PIN_N_O && !SYSTEM_FAULT_PIN_N_O && !IRQ_PIN_N_O)
        else $error("pin drive level high");
    sys_hold_a: assert property ($rose(SYSTEM_FAULT_PIN_OE) |-> SYSTEM_FAULT_PIN_OE[*6]) else $error("sys pin short");
    par_hold_a: assert property ($rose(PARITY_FAULT_PIN_OE) |-> PARITY_FAULT_PIN_OE[*6]) else $error("par pin short");

    cover property (rd_cs);
    cover property (PREADY && PSLVERR);
    cover property ($rose(SYSTEM_FAULT_PIN_OE));
    cover property ($rose(IRQ_PIN_OE));
endmodule

bind pcm_cfg_mirror pcm_cfg_mirror_properties #(.CAP_CHAIN(CAP_CHAIN)) chk_u (.CLOCK(CLOCK), .RSTN(RSTN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FUNC_IRQ_STATE(FUNC_IRQ_STATE), .PARITY_FAULT_PIN_N_O(PARITY_FAULT_PIN_N_O),
    .PARITY_FAULT_PIN_OE(PARITY_FAULT_PIN_OE), .SYSTEM_FAULT_PIN_N_O(SYSTEM_FAULT_PIN_N_O),
    .SYSTEM_FAULT_PIN_OE(SYSTEM_FAULT_PIN_OE), .IRQ_PIN_N_O(IRQ_PIN_N_O), .IRQ_PIN_OE(IRQ_PIN_OE));

// >>> verification/pcm_pci_agent.sv
// Behavioural PCI-side agent: bus clock and event lines.
// Assumes the bench resolves the parity fault wire with a pull-up.
module pcm_pci_agent (
    output logic link_clk,
    output logic par_evt,
    output logic sys_req,
    output logic init_ab,
    output logic resp_ab,
    output logic owner,
    output logic perr_drive
);
    timeunit 1ns;
    timeprecision 1ns;
    // Bus clock runs continuously
    initial link_clk = 1'b0;
    always #80 link_clk = ~link_clk;
    initial {resp_ab, init_ab, sys_req, par_evt, owner, perr_drive} = 6'h00;
    // Hold one event set across one bus clock rise
    task send(input logic [3:0] ev, input logic own, input logic pin);
        begin
            @(negedge link_clk);
            {resp_ab, init_ab, sys_req, par_evt} = ev;
            owner = own;
            perr_drive = pin;
            @(negedge link_clk);
            {resp_ab, init_ab, sys_req, par_evt, owner, perr_drive} = 6'h00;
        end
    endtask
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the configuration mirror over APB.
// Assumes the PCI-side agent model and the bound property checker.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] ID = pcm_pkg::IDENT_OFFSET;
    localparam logic [11:0] CS = pcm_pkg::CMDSTAT_OFFSET;
    localparam logic [31:0] FIX = {5'h0, pcm_pkg::SEL_SPEED_VAL, 4'h0, pcm_pkg::CAP_CHAIN_DEFAULT, 20'h0};
    logic        clock = 1'b0;
    logic        rstn, psel, penable, pwrite, func_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic        pready, pslverr, par_oe, par_no, sys_oe, sys_no, irq_oe, irq_no;
    logic        lclk, par_evt, sys_req, init_ab, resp_ab, owner, perr_drive, par_wire;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    int          fails = 0;
    int          total_checks = 0;
    int          seed = 4;
    int          oe_cnt = 0;
    int          oe_base = 0;
    always #10 clock = ~clock;
    assign par_wire = ~(par_oe & ~par_no) & ~perr_drive;

    pcm_pci_agent agent_u (.link_clk(lclk), .par_evt(par_evt), .sys_req(sys_req), .init_ab(init_ab),
        .resp_ab(resp_ab), .owner(owner), .perr_drive(perr_drive));
    pcm_cfg_mirror dut_u (.CLOCK(clock), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .LINK_CLK(lclk), .PAR_FAULT_EVT(par_evt), .SYS_FAULT_REQ(sys_req), .INIT_ABORT_EVT(init_ab),
        .RESP_ABORT_EVT(resp_ab), .BUS_OWNER(owner), .FUNC_IRQ_STATE(func_irq),
        .PARITY_FAULT_PIN_N_I(par_wire), .PARITY_FAULT_PIN_N_O(par_no), .PARITY_FAULT_PIN_OE(par_oe),
        .SYSTEM_FAULT_PIN_N_O(sys_no), .SYSTEM_FAULT_PIN_OE(sys_oe), .IRQ_PIN_N_O(irq_no), .IRQ_PIN_OE(irq_oe));

    task check(input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task wrap_up;
        if (fails == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One APB transfer; psel stays up for a following setup
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x, input logic er);
        exp_q.push_back({~w, er, x});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        penable <= 1'b0;
    endtask
    task idle;
        psel <= 1'b0;
        @(posedge clock);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, x, 1'b0);
    endtask
    task ev(input logic [3:0] k, input logic own, input logic pin);
        agent_u.send(k, own, pin);
        repeat (20) @(posedge clock);
    endtask

    // Cycles with a fault pin driven, parity and system summed in one count
    always @(posedge clock) if (rstn) oe_cnt <= oe_cnt + int'(par_oe) + int'(sys_oe);
    always @(posedge clock) if (rstn && pready === 1'b1) begin
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h0;
        check({31'h0, pslverr}, {31'h0, e[32]});
        if (e[33]) check(prdata, e[31:0]);
    end
    initial begin
        #100000;
        fails++;
        wrap_up;
    end
    initial begin
        {rstn, psel, penable, pwrite, func_irq} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        rd(ID, {pcm_pkg::PART_ID_RESET, pcm_pkg::MAKER_ID_RESET});
        rd(CS, FIX);
        for (int i = 0; i < 3; i++) begin
            v = $random(seed);
            apb(1'b1, ID, v, 32'h0, 1'b0);
            rd(ID, v);
        end
        apb(1'b1, 12'h008, 32'hffff_ffff, 32'h0, 1'b1);
        apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
        rd(ID, v);
        apb(1'b1, CS, 32'hffff_ffff, 32'h0, 1'b0);
        rd(CS, FIX | 32'h540);
        idle;
        oe_base = oe_cnt;
        ev(4'hf, 1'b1, 1'b0);
        check(oe_cnt - oe_base, 32'h10);
        rd(CS, FIX | 32'hf100_0540);
        apb(1'b1, CS, 32'h8100_0540, 32'h0, 1'b0);
        rd(CS, FIX | 32'h7000_0540);
        apb(1'b1, CS, 32'hf100_0400, 32'h0, 1'b0);
        rd(CS, FIX | 32'h400);
        idle;
        oe_base = oe_cnt;
        ev(4'h3, 1'b1, 1'b0);
        rd(CS, FIX | 32'h8000_0400);
        check(oe_cnt - oe_base, 32'h0);
        apb(1'b1, CS, 32'h8000_0040, 32'h0, 1'b0);
        idle;
        ev(4'hc, 1'b0, 1'b1);
        rd(CS, FIX | 32'h40);
        idle;
        ev(4'h0, 1'b1, 1'b1);
        func_irq <= 1'b1;
        repeat (4) @(posedge clock);
        check({31'h0, irq_oe}, 32'h1);
        rd(CS, FIX | 32'h0108_0040);
        apb(1'b1, CS, 32'h0100_0440, 32'h0, 1'b0);
        idle;
        repeat (3) @(posedge clock);
        check({31'h0, irq_oe}, 32'h0);
        rd(CS, FIX | 32'h0008_0440);
        idle;
        repeat (3) @(posedge clock);
        wrap_up;
    end
endmodule
